/* File: core/owr_map.svh */
`ifndef OWR_MAP_SVH
`define OWR_MAP_SVH
// What this block does
// - mask bit k of each window governs display column k, k from 0 to 31.
// - clear mask bit gives a 12-pixel column; set bit gives 24 pixels.
// - in a double column each font pixel is shown in two adjacent positions.
// - characters after the first 32 of a row are always normal width.
// - window 2 horizontal start is value times 4 plus 30 OSD pixels.
// - window 2 vertical start is twice the value in character lines.
// - 9-bit page address where window 2 starts, holding its first row-start code.
// - blue, green, red gains are 7-bit fields; top bit reserved, reads zero.
// - 7-bit contrast scales all three colour channels together.
// - first two bias output registers each hold a full 8-bit code.
// - bit 5 of the shared DAC configuration picks the bias full-scale range.
// - config bit clear gives 4.5 V full scale, set gives 2.5 V.

// register offsets
`define OWR_W1_MASK_OFS 16'h8414
`define OWR_HPOS_OFS 16'h8418
`define OWR_VPOS_OFS 16'h8419
`define OWR_BASE_OFS 16'h841A
`define OWR_W2_MASK_OFS 16'h841C
`define OWR_BLUE_OFS 16'h8430
`define OWR_GREEN_OFS 16'h8431
`define OWR_RED_OFS 16'h8432
`define OWR_CONTR_OFS 16'h8433
`define OWR_BIAS1_OFS 16'h8434
`define OWR_BIAS2_OFS 16'h8435

// reset values
`define OWR_W1_MASK_RST 32'h0000_0000
`define OWR_W2_MASK_RST 32'h0000_0000
`define OWR_HPOS_RST 8'h00
`define OWR_VPOS_RST 8'h00
`define OWR_BASE_RST 9'h000
`define OWR_GAIN_RST 7'h00
`define OWR_CONTR_RST 7'h00
`define OWR_BIAS_RST 8'h00

// field positions and geometry
`define OWR_DAC_RANGE_BIT 5
`define OWR_HPOS_OFFSET_PX 11'h01E
`define OWR_MASK_COLS 8'h20
`define OWR_NORMAL_PX 5'h0C
`define OWR_DOUBLE_PX 5'h18
`endif

/* File: core/owr_pkg.sv */
package owr_pkg;
    // register selected by a bus address
    typedef enum logic [3:0] {
        OWR_SEL_NONE,
        OWR_SEL_W1_MASK,
        OWR_SEL_HPOS,
        OWR_SEL_VPOS,
        OWR_SEL_BASE,
        OWR_SEL_W2_MASK,
        OWR_SEL_BLUE,
        OWR_SEL_GREEN,
        OWR_SEL_RED,
        OWR_SEL_CONTR,
        OWR_SEL_BIAS1,
        OWR_SEL_BIAS2
    } owr_sel_t;
endpackage

/* File: core/owr_col_width.sv */
`timescale 1ns/1ps
`include "owr_map.svh"
module owr_col_width import owr_pkg::*; (
    input wire logic [31:0] mask,
    input wire logic [7:0] char_index,
    input wire logic [4:0] pixel_in_col,
    output logic dbl,
    output logic [4:0] col_pixels,
    output logic [3:0] font_col
);
    // width of one column and the font pixel shown at a position
    always_comb begin
        dbl = (char_index < `OWR_MASK_COLS) && mask[char_index[4:0]];
        col_pixels = dbl ? `OWR_DOUBLE_PX : `OWR_NORMAL_PX;
        if (dbl) begin
            font_col = pixel_in_col[4:1];
        end else begin
            font_col = pixel_in_col[3:0];
        end
    end
endmodule

/* File: core/owr_regs.sv */
`timescale 1ns/1ps
`include "owr_map.svh"
module owr_regs import owr_pkg::*; (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [15:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    output logic [31:0] win1_col_mask,
    output logic [31:0] win2_col_mask,
    output logic [7:0] second_window_hpos,
    output logic [7:0] second_window_vpos,
    output logic [8:0] second_window_base,
    output logic [10:0] win2_hstart_px,
    output logic [8:0] win2_vstart_lines,
    output logic [6:0] blue_gain_setting,
    output logic [6:0] green_gain_setting,
    output logic [6:0] red_gain_setting,
    output logic [6:0] contrast_setting,
    output logic [7:0] bias_code_one,
    output logic [7:0] bias_code_two,
    input wire logic [7:0] dac_config_register,
    output logic bias_fullscale_low,
    input wire logic rend_win_sel,
    input wire logic [7:0] rend_char_index,
    input wire logic [4:0] rend_pixel_in_col,
    input wire logic [8:0] rend_page_addr,
    output logic rend_double,
    output logic [4:0] rend_col_pixels,
    output logic [3:0] rend_font_col,
    output logic rend_row_start
);
    // address decode, shared by the write and read paths
    function automatic owr_sel_t decode(input logic [15:0] a);
        if ({a[15:2], 2'b00} == `OWR_W1_MASK_OFS) begin
            decode = OWR_SEL_W1_MASK;
        end else if ({a[15:2], 2'b00} == `OWR_W2_MASK_OFS) begin
            decode = OWR_SEL_W2_MASK;
        end else if ({a[15:1], 1'b0} == `OWR_BASE_OFS) begin
            decode = OWR_SEL_BASE;
        end else begin
            case (a)
                `OWR_HPOS_OFS: decode = OWR_SEL_HPOS;
                `OWR_VPOS_OFS: decode = OWR_SEL_VPOS;
                `OWR_BLUE_OFS: decode = OWR_SEL_BLUE;
                `OWR_GREEN_OFS: decode = OWR_SEL_GREEN;
                `OWR_RED_OFS: decode = OWR_SEL_RED;
                `OWR_CONTR_OFS: decode = OWR_SEL_CONTR;
                `OWR_BIAS1_OFS: decode = OWR_SEL_BIAS1;
                `OWR_BIAS2_OFS: decode = OWR_SEL_BIAS2;
                default: decode = OWR_SEL_NONE;
            endcase
        end
    endfunction

    owr_sel_t wr_sel;
    owr_sel_t rd_sel;
    logic [31:0] next_win1_col_mask;
    logic [31:0] next_win2_col_mask;
    logic [7:0] next_hpos;
    logic [7:0] next_vpos;
    logic [8:0] next_base;
    logic [10:0] next_hstart_px;
    logic [8:0] next_vstart_lines;
    logic [6:0] next_blue;
    logic [6:0] next_green;
    logic [6:0] next_red;
    logic [6:0] next_contrast;
    logic [7:0] next_bias_one;
    logic [7:0] next_bias_two;
    logic next_fullscale_low;
    logic [7:0] next_rdata;
    logic next_rvalid;
    logic cw_dbl;
    logic [4:0] cw_pixels;
    logic [3:0] cw_font_col;
    logic next_row_start;

    assign wr_sel = decode(reg_addr);
    assign rd_sel = decode(reg_addr);

    // register writes; unmapped addresses are ignored
    always_comb begin
        next_win1_col_mask = win1_col_mask;
        next_win2_col_mask = win2_col_mask;
        next_hpos = second_window_hpos;
        next_vpos = second_window_vpos;
        next_base = second_window_base;
        next_blue = blue_gain_setting;
        next_green = green_gain_setting;
        next_red = red_gain_setting;
        next_contrast = contrast_setting;
        next_bias_one = bias_code_one;
        next_bias_two = bias_code_two;
        if (reg_wr) begin
            case (wr_sel)
                OWR_SEL_W1_MASK: next_win1_col_mask[8 * reg_addr[1:0] +: 8] = reg_wdata;
                OWR_SEL_W2_MASK: next_win2_col_mask[8 * reg_addr[1:0] +: 8] = reg_wdata;
                OWR_SEL_HPOS: next_hpos = reg_wdata;
                OWR_SEL_VPOS: next_vpos = reg_wdata;
                OWR_SEL_BASE: begin
                    if (reg_addr[0]) begin
                        next_base[8] = reg_wdata[0];
                    end else begin
                        next_base[7:0] = reg_wdata;
                    end
                end
                OWR_SEL_BLUE: next_blue = reg_wdata[6:0];
                OWR_SEL_GREEN: next_green = reg_wdata[6:0];
                OWR_SEL_RED: next_red = reg_wdata[6:0];
                OWR_SEL_CONTR: next_contrast = reg_wdata[6:0];
                OWR_SEL_BIAS1: next_bias_one = reg_wdata;
                OWR_SEL_BIAS2: next_bias_two = reg_wdata;
                default: next_hpos = second_window_hpos;
            endcase
        end
        next_hstart_px = {1'b0, next_hpos, 2'b00} + `OWR_HPOS_OFFSET_PX;
        next_vstart_lines = {next_vpos, 1'b0};
        next_fullscale_low = dac_config_register[`OWR_DAC_RANGE_BIT];
    end

    // control register state
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            win1_col_mask <= `OWR_W1_MASK_RST;
            win2_col_mask <= `OWR_W2_MASK_RST;
            second_window_hpos <= `OWR_HPOS_RST;
            second_window_vpos <= `OWR_VPOS_RST;
            second_window_base <= `OWR_BASE_RST;
            win2_hstart_px <= {1'b0, `OWR_HPOS_RST, 2'b00} + `OWR_HPOS_OFFSET_PX;
            win2_vstart_lines <= {`OWR_VPOS_RST, 1'b0};
            blue_gain_setting <= `OWR_GAIN_RST;
            green_gain_setting <= `OWR_GAIN_RST;
            red_gain_setting <= `OWR_GAIN_RST;
            contrast_setting <= `OWR_CONTR_RST;
            bias_code_one <= `OWR_BIAS_RST;
            bias_code_two <= `OWR_BIAS_RST;
            bias_fullscale_low <= 1'b0;
        end else begin
            win1_col_mask <= next_win1_col_mask;
            win2_col_mask <= next_win2_col_mask;
            second_window_hpos <= next_hpos;
            second_window_vpos <= next_vpos;
            second_window_base <= next_base;
            win2_hstart_px <= next_hstart_px;
            win2_vstart_lines <= next_vstart_lines;
            blue_gain_setting <= next_blue;
            green_gain_setting <= next_green;
            red_gain_setting <= next_red;
            contrast_setting <= next_contrast;
            bias_code_one <= next_bias_one;
            bias_code_two <= next_bias_two;
            bias_fullscale_low <= next_fullscale_low;
        end
    end

    // read mux; reserved bits and unmapped addresses read as zero
    always_comb begin
        next_rdata = 8'h00;
        next_rvalid = reg_rd;
        if (reg_rd) begin
            case (rd_sel)
                OWR_SEL_W1_MASK: next_rdata = win1_col_mask[8 * reg_addr[1:0] +: 8];
                OWR_SEL_W2_MASK: next_rdata = win2_col_mask[8 * reg_addr[1:0] +: 8];
                OWR_SEL_HPOS: next_rdata = second_window_hpos;
                OWR_SEL_VPOS: next_rdata = second_window_vpos;
                OWR_SEL_BASE: next_rdata = reg_addr[0] ? {7'h00, second_window_base[8]} : second_window_base[7:0];
                OWR_SEL_BLUE: next_rdata = {1'b0, blue_gain_setting};
                OWR_SEL_GREEN: next_rdata = {1'b0, green_gain_setting};
                OWR_SEL_RED: next_rdata = {1'b0, red_gain_setting};
                OWR_SEL_CONTR: next_rdata = {1'b0, contrast_setting};
                OWR_SEL_BIAS1: next_rdata = bias_code_one;
                OWR_SEL_BIAS2: next_rdata = bias_code_two;
                default: next_rdata = 8'h00;
            endcase
        end
    end

    // read answer, one cycle after the strobe
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rdata <= next_rdata;
            reg_rvalid <= next_rvalid;
        end
    end

    // column geometry for the renderer, mask picked by window
    owr_col_width u_col_width (
        .mask(rend_win_sel ? win2_col_mask : win1_col_mask),
        .char_index(rend_char_index),
        .pixel_in_col(rend_pixel_in_col),
        .dbl(cw_dbl),
        .col_pixels(cw_pixels),
        .font_col(cw_font_col)
    );

    always_comb begin
        next_row_start = (rend_page_addr == second_window_base);
    end

    // renderer answers, registered so the outputs are clean
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rend_double <= 1'b0;
            rend_col_pixels <= `OWR_NORMAL_PX;
            rend_font_col <= 4'h0;
            rend_row_start <= 1'b0;
        end else begin
            rend_double <= cw_dbl;
            rend_col_pixels <= cw_pixels;
            rend_font_col <= cw_font_col;
            rend_row_start <= next_row_start;
        end
    end

    // checks on the register and renderer behaviour
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);

    a_mask_byte_write: assert property (
        reg_wr && reg_addr == (`OWR_W1_MASK_OFS + 16'h0001) |=> win1_col_mask[15:8] == $past(reg_wdata)
    ) else $error("window 1 mask byte 1 not stored");

    a_width_double: assert property (
        rend_double |-> rend_col_pixels == `OWR_DOUBLE_PX
    ) else $error("double column not 24 pixels");

    a_font_repeat: assert property (
        ##1 rend_double |-> rend_font_col == $past(rend_pixel_in_col[4:1])
    ) else $error("double column font pixel not repeated");

    a_beyond_thirtytwo: assert property (
        rend_char_index >= `OWR_MASK_COLS |=> !rend_double && rend_col_pixels == `OWR_NORMAL_PX
    ) else $error("column past 32 drawn wide");

    a_hstart_formula: assert property (
        win2_hstart_px == {1'b0, second_window_hpos, 2'b00} + `OWR_HPOS_OFFSET_PX
    ) else $error("window 2 horizontal start wrong");

    a_vstart_twice: assert property (
        reg_wr && reg_addr == `OWR_VPOS_OFS |=> win2_vstart_lines == {$past(reg_wdata), 1'b0}
    ) else $error("window 2 vertical start not doubled");

    a_row_start_hit: assert property (
        rend_page_addr == second_window_base |=> rend_row_start
    ) else $error("row start not flagged at window 2 base");

    a_gain_top_zero: assert property (
        reg_rd && reg_addr == `OWR_BLUE_OFS |=> reg_rvalid && reg_rdata[7] == 1'b0
    ) else $error("gain reserved bit reads nonzero");

    a_contrast_store: assert property (
        reg_wr && reg_addr == `OWR_CONTR_OFS |=> contrast_setting == $past(reg_wdata[6:0])
    ) else $error("contrast not stored");

    a_bias_code: assert property (
        reg_wr && reg_addr == `OWR_BIAS2_OFS |=> bias_code_two == $past(reg_wdata)
    ) else $error("bias code two not stored");

    a_range_follow: assert property (
        ##1 bias_fullscale_low == $past(dac_config_register[`OWR_DAC_RANGE_BIT])
    ) else $error("bias range select does not follow config");

    a_base_low_byte: assert property (
        reg_wr && reg_addr == `OWR_BASE_OFS |=> second_window_base[7:0] == $past(reg_wdata)
    ) else $error("base low byte not at lowest address");

    a_mask_top_byte: assert property (
        reg_wr && reg_addr == (`OWR_W2_MASK_OFS + 16'h0003) |=> win2_col_mask[31:24] == $past(reg_wdata)
    ) else $error("window 2 mask top byte not stored");

    a_width_normal: assert property (
        !rend_double |-> rend_col_pixels == `OWR_NORMAL_PX
    ) else $error("normal column not 12 pixels");

    a_font_single: assert property (
        ##1 !rend_double |-> rend_font_col == $past(rend_pixel_in_col[3:0])
    ) else $error("normal column font pixel wrong");

    a_col_pick_one: assert property (
        rend_char_index < `OWR_MASK_COLS && !rend_win_sel
            |=> rend_double == $past(win1_col_mask[rend_char_index[4:0]])
    ) else $error("window 1 column width bit not followed");

    a_col_pick_two: assert property (
        rend_char_index < `OWR_MASK_COLS && rend_win_sel
            |=> rend_double == $past(win2_col_mask[rend_char_index[4:0]])
    ) else $error("window 2 column width bit not followed");

    a_hstart_write: assert property (
        reg_wr && reg_addr == `OWR_HPOS_OFS |=> win2_hstart_px == {1'b0, $past(reg_wdata), 2'b00} + 11'h01E
    ) else $error("window 2 horizontal start not updated");

    a_base_high_bit: assert property (
        reg_wr && reg_addr == (`OWR_BASE_OFS + 16'h0001) |=> second_window_base[8] == $past(reg_wdata[0])
    ) else $error("base bit 8 not stored");

    a_row_start_miss: assert property (
        rend_page_addr != second_window_base |=> !rend_row_start
    ) else $error("row start flagged away from base");

    a_blue_store: assert property (
        reg_wr && reg_addr == `OWR_BLUE_OFS |=> blue_gain_setting == $past(reg_wdata[6:0])
    ) else $error("blue gain not stored");

    a_green_store: assert property (
        reg_wr && reg_addr == `OWR_GREEN_OFS |=> green_gain_setting == $past(reg_wdata[6:0])
    ) else $error("green gain not stored");

    a_red_store: assert property (
        reg_wr && reg_addr == `OWR_RED_OFS |=> red_gain_setting == $past(reg_wdata[6:0])
    ) else $error("red gain not stored");

    a_bias_one_code: assert property (
        reg_wr && reg_addr == `OWR_BIAS1_OFS |=> bias_code_one == $past(reg_wdata)
    ) else $error("bias code one not stored");

    a_mask_readback: assert property (
        reg_rd && reg_addr == `OWR_W1_MASK_OFS |=> reg_rdata == $past(win1_col_mask[7:0])
    ) else $error("mask low byte not read at lowest address");

    c_hpos_write: cover property (reg_wr && reg_addr == `OWR_HPOS_OFS);
    c_double_col: cover property (rend_double);
    c_mask_read: cover property (reg_rd && reg_addr == `OWR_W2_MASK_OFS + 16'h0003);
    c_row_start: cover property (rend_row_start);
    c_range_low: cover property (bias_fullscale_low);
endmodule

/* File: tb/owr_host.sv */
`timescale 1ns/1ps
module owr_host #(
    parameter logic [7:0] VPOS_MAX = 8'h60
) (
    input wire logic clk,
    output logic [15:0] reg_addr,
    output logic reg_wr,
    output logic [7:0] reg_wdata,
    output logic reg_rd
);
    // parked bus at time zero
    initial begin
        reg_addr = 16'h0000;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        reg_rd = 1'b0;
    end
    // values a careful host would program
    function automatic logic [7:0] legal(input logic [15:0] a, input logic [7:0] d);
        case (a)
            16'h8418: return (d < 8'h03) ? d + 8'h03 : d;
            16'h8419: return (d > VPOS_MAX) ? VPOS_MAX : d;
            16'h841B: return d & 8'h01;
            default: return d;
        endcase
    endfunction
    // one byte per call, caller sits at a falling edge; strobe held for back to back
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        reg_rd = 1'b0;
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = legal(a, d);
        @(negedge clk);
    endtask
    task automatic rd(input logic [15:0] a);
        reg_wr = 1'b0;
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge clk);
    endtask
    // released lines show inverted junk so nothing leans on stale values
    task automatic idle();
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = ~reg_addr;
        reg_wdata = ~reg_wdata;
        @(negedge clk);
    endtask
endmodule

/* File: tb/owr_regs_bench.sv */
`timescale 1ns/1ps
module owr_regs_bench import owr_pkg::*;;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [15:0] reg_addr;
    logic reg_wr, reg_rd, reg_rvalid, bias_fullscale_low, rend_double, rend_row_start, dbl;
    logic [7:0] reg_wdata, reg_rdata, second_window_hpos, second_window_vpos, bias_code_one, bias_code_two;
    logic [31:0] win1_col_mask, win2_col_mask, m;
    logic [8:0] second_window_base, win2_vstart_lines;
    logic [10:0] win2_hstart_px;
    logic [6:0] blue_gain_setting, green_gain_setting, red_gain_setting, contrast_setting;
    logic [7:0] dac_config_register = 8'h00;
    logic rend_win_sel = 1'b0;
    logic [7:0] rend_char_index = 8'h00;
    logic [4:0] rend_pixel_in_col = 5'h00;
    logic [8:0] rend_page_addr = 9'h000;
    logic [4:0] rend_col_pixels;
    logic [3:0] rend_font_col;
    logic [7:0] lf = 8'h25;
    logic [7:0] sh [64];
    logic [7:0] q [$];
    logic [15:0] a;
    int mismatches = 0;
    int check_count = 0;

    owr_regs uut (.clk, .arst_n, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .reg_rvalid,
        .win1_col_mask, .win2_col_mask, .second_window_hpos, .second_window_vpos, .second_window_base,
        .win2_hstart_px, .win2_vstart_lines, .blue_gain_setting, .green_gain_setting, .red_gain_setting,
        .contrast_setting, .bias_code_one, .bias_code_two, .dac_config_register, .bias_fullscale_low,
        .rend_win_sel, .rend_char_index, .rend_pixel_in_col, .rend_page_addr, .rend_double,
        .rend_col_pixels, .rend_font_col, .rend_row_start);
    owr_host host (.clk, .reg_addr, .reg_wr, .reg_wdata, .reg_rd);

    always #4 clk = ~clk;

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    // bits the device keeps per byte; unmapped reads as zero
    function automatic logic [7:0] keep(input logic [15:0] x);
        if (x == 16'h841B) return 8'h01;
        if (x >= 16'h8430 && x <= 16'h8433) return 8'h7F;
        if ((x >= 16'h8414 && x <= 16'h841F) || (x >= 16'h8430 && x <= 16'h8435)) return 8'hFF;
        return 8'h00;
    endfunction
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // read answers matched against the oldest note
    always @(negedge clk) begin
        if (reg_rvalid === 1'b1) begin
            if (q.size() == 0) chk("rvalid", 32'h0, 32'h1);
            else chk("rdata", q.pop_front(), reg_rdata);
        end
    end

    initial begin
        #20000;
        mismatches++;
        results();
    end

    initial begin
        repeat (4) @(negedge clk);
        chk("hstart_rst", 30, win2_hstart_px);
        chk("cols_rst", 12, rend_col_pixels);
        arst_n = 1'b1;
        // every byte and the unmapped gaps read back to back
        for (a = 16'h8412; a <= 16'h8437; a++) begin
            q.push_back(8'h00);
            host.rd(a);
        end
        host.idle();
        // random bytes, gain top bit forced to exercise the reserved bit
        for (a = 16'h8412; a <= 16'h8437; a++) begin
            lf = lfsr(lf);
            host.wr(a, lf | ((keep(a) == 8'h7F) ? 8'h80 : 8'h00));
            sh[a[5:0]] = host.legal(a, lf) & keep(a);
        end
        host.idle();
        for (a = 16'h8412; a <= 16'h8437; a++) begin
            q.push_back(sh[a[5:0]]);
            host.rd(a);
        end
        host.idle();
        chk("w1mask", {sh[23], sh[22], sh[21], sh[20]}, win1_col_mask);
        chk("w2mask", {sh[31], sh[30], sh[29], sh[28]}, win2_col_mask);
        chk("hpos", sh[24], second_window_hpos);
        chk("hstart", {1'b0, sh[24], 2'b00} + 11'h01E, win2_hstart_px);
        chk("vlines", {sh[25], 1'b0}, win2_vstart_lines);
        chk("base", {sh[27][0], sh[26]}, second_window_base);
        chk("gains", {sh[48][6:0], sh[49][6:0], sh[50][6:0]},
            {blue_gain_setting, green_gain_setting, red_gain_setting});
        chk("contrast", sh[51][6:0], contrast_setting);
        chk("bias", {sh[52], sh[53]}, {bias_code_one, bias_code_two});
        rend_page_addr = {sh[27][0], sh[26]};
        @(negedge clk);
        chk("row_start", 1, rend_row_start);
        rend_page_addr = rend_page_addr ^ 9'h001;
        @(negedge clk);
        chk("row_other", 0, rend_row_start);
        repeat (6) begin
            lf = lfsr(lf);
            dac_config_register = lf;
            @(negedge clk);
            chk("fullscale", lf[5], bias_fullscale_low);
        end
        // both windows, columns across the 32 boundary
        for (int i = 0; i < 82; i++) begin
            m = i[0] ? {sh[31], sh[30], sh[29], sh[28]} : {sh[23], sh[22], sh[21], sh[20]};
            dbl = (i / 2 < 32) ? m[i / 2] : 1'b0;
            lf = lfsr(lf);
            rend_win_sel = i[0];
            rend_char_index = 8'(i / 2);
            rend_pixel_in_col = dbl ? 5'(lf % 24) : 5'(lf % 12);
            @(negedge clk);
            chk("double", dbl, rend_double);
            chk("cols", dbl ? 24 : 12, rend_col_pixels);
            chk("font", dbl ? rend_pixel_in_col >> 1 : rend_pixel_in_col[3:0], rend_font_col);
        end
        // mid-run reset returns every setting to its reset value
        arst_n = 1'b0;
        @(negedge clk);
        chk("w1mask_rst", 0, win1_col_mask);
        chk("hstart_rst2", 30, win2_hstart_px);
        chk("base_rst", 0, second_window_base);
        chk("bias_rst", 0, {bias_code_one, bias_code_two});
        arst_n = 1'b1;
        q.push_back(8'h00);
        host.rd(16'h8430);
        host.idle();
        results();
    end
endmodule
